// *** lbatf_pkg.sv ***
// Package of constants for the 48-bit task-file register block
package lbatf_pkg;

  // ****************************************
  // Register selects on the host access port
  // ****************************************
  localparam logic [3:0] REG_DATA     = 4'h0;
  localparam logic [3:0] REG_FEATURES = 4'h1;
  localparam logic [3:0] REG_SECCNT   = 4'h2;
  localparam logic [3:0] REG_SECNUM   = 4'h3;
  localparam logic [3:0] REG_CYLLO    = 4'h4;
  localparam logic [3:0] REG_CYLHI    = 4'h5;
  localparam logic [3:0] REG_DEVHEAD  = 4'h6;
  localparam logic [3:0] REG_COMMAND  = 4'h7;
  localparam logic [3:0] REG_DEVCTL   = 4'he;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          UPPER_SEL_BIT = 7;
  localparam int          LBA_MODE_BIT  = 6;
  localparam logic [7:0]  DEVCTL_RST    = 8'h00;
  localparam logic [7:0]  FIFO_RST      = 8'h00;
  localparam int          NUM_PAIRS     = 5;

  // ****************************************
  // Addressing limits and identify data
  // ****************************************
  localparam logic [47:0] LBA28_LIMIT   = 48'h000_0fff_ffff;
  localparam logic [47:0] NATIVE_MAX_DFLT = 48'h0000_0100_0000;
  localparam logic [6:0]  ID_WORD_CMDSET = 7'h53;
  localparam int          ID_BIT_LBA48  = 10;
  localparam logic [6:0]  ID_WORD_MAXLO = 7'h64;
  localparam logic [6:0]  ID_WORD_MAXHI = 7'h67;

endpackage : lbatf_pkg

// *** lbatf_pair.sv ***
// Two-entry register holding the newest and prior written bytes
`timescale 1ns/1ps
module lbatf_pair (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Entries
  output logic      [7:0] newest,
  output logic      [7:0] prior
);

  // Newest moves to prior and the written byte becomes newest
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      newest <= lbatf_pkg::FIFO_RST;
      prior  <= lbatf_pkg::FIFO_RST;
    end else if (wr_en) begin
      newest <= wr_data;
      prior  <= newest;
    end
  end

endmodule : lbatf_pair

// *** lbatf_regs.sv ***
// Task-file register block with two-deep registers for 48-bit addressing
//
// Functional notes
// - Features, count, sector number, cylinder low/high each hold newest and prior entry.
// - Each write shifts newest into prior and stores written byte as newest.
// - With upper-byte select at bit 7 set, reads return the prior entry.
// - With upper-byte select clear, reads return the newest entry.
// - Any command-block register write clears the upper-byte select bit.
// - Writes always load the newest entry regardless of upper-byte select.
// - 48-bit commands see the sector count as a 16-bit value.
// - Logical block addresses are 48 bits wide.
// - 48-bit commands use logical block addressing only, never CHS.
// - 28-bit and 48-bit commands may be freely interleaved.
// - 28-bit native max query returns native max clamped to 268,435,455.
// - Identify word 83 bit 10 reports 48-bit addressing support.
// - Identify words 100 to 103 hold the highest 48-bit user address.
// - Native maximum equals the 48-bit native max query answer.
`timescale 1ns/1ps
module lbatf_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host register access
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [3:0]  reg_sel,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  // Command issue
  output logic             cmd_valid,
  output logic      [7:0]  cmd_code,
  output logic             cmd_is_48,
  output logic             cmd_lba_mode,
  output logic             cmd_chs_err,
  output logic      [15:0] cmd_count,
  output logic      [15:0] cmd_features,
  output logic      [47:0] cmd_lba,
  output logic             upper_byte_read_select,
  // Native maximum and identify
  input  wire logic [47:0] native_max,
  input  wire logic        cmd_ext_in,
  output logic      [47:0] max_answer_48,
  output logic      [47:0] max_answer_28,
  input  wire logic [6:0]  id_word_sel,
  output logic      [15:0] id_word
);

  // ****************************************
  // Two-deep registers
  // ****************************************
  logic [7:0] pair_new [lbatf_pkg::NUM_PAIRS];
  logic [7:0] pair_old [lbatf_pkg::NUM_PAIRS];
  logic [3:0] pair_sel [lbatf_pkg::NUM_PAIRS];

  assign pair_sel[0] = lbatf_pkg::REG_FEATURES;
  assign pair_sel[1] = lbatf_pkg::REG_SECCNT;
  assign pair_sel[2] = lbatf_pkg::REG_SECNUM;
  assign pair_sel[3] = lbatf_pkg::REG_CYLLO;
  assign pair_sel[4] = lbatf_pkg::REG_CYLHI;

  // One two-entry register per features, count, sector number and cylinder byte
  genvar gi;
  generate
    for (gi = 0; gi < lbatf_pkg::NUM_PAIRS; gi++) begin : g_pair
      lbatf_pair u_pair (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (wr_en && (reg_sel == pair_sel[gi])),
        .wr_data (wr_data),
        .newest  (pair_new[gi]),
        .prior   (pair_old[gi])
      );
    end
  endgenerate

  // ****************************************
  // Decode
  // ****************************************
  wire        wr_devctl  = wr_en && (reg_sel == lbatf_pkg::REG_DEVCTL);
  wire        wr_cmdblk  = wr_en && (reg_sel[3] == 1'b0);
  wire        wr_devhead = wr_en && (reg_sel == lbatf_pkg::REG_DEVHEAD);
  wire        wr_command = wr_en && (reg_sel == lbatf_pkg::REG_COMMAND);
  wire        ub_sel     = upper_byte_read_select;

  logic [7:0] devhead_r;
  logic [7:0] devctl_r;

  // Upper-byte select set by control write, cleared by any command-block write
  wire [7:0] devctl_nxt = wr_devctl ? wr_data :
                          wr_cmdblk ? (devctl_r & 8'h7f) : devctl_r;

  // Read mux: prior entry when upper-byte select set
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < lbatf_pkg::NUM_PAIRS; i++) begin
      if (reg_sel == pair_sel[i]) begin
        rd_mux = ub_sel ? pair_old[i] : pair_new[i];
      end
    end
    if (reg_sel == lbatf_pkg::REG_DEVHEAD) begin
      rd_mux = devhead_r;
    end
    if (reg_sel == lbatf_pkg::REG_DEVCTL) begin
      rd_mux = devctl_r;
    end
  end

  // ****************************************
  // Command field assembly
  // ****************************************
  wire [15:0] count_16 = {pair_old[1], pair_new[1]};
  wire [15:0] feat_16  = {pair_old[0], pair_new[0]};
  wire [47:0] lba_48   = {pair_old[4], pair_old[3], pair_old[2],
                          pair_new[4], pair_new[3], pair_new[2]};
  wire [47:0] lba_28   = {20'h00000, devhead_r[3:0], pair_new[4], pair_new[3], pair_new[2]};
  wire        lba_mode = devhead_r[lbatf_pkg::LBA_MODE_BIT];
  wire [47:0] clamp_28 = (native_max <= lbatf_pkg::LBA28_LIMIT) ?
                         native_max : lbatf_pkg::LBA28_LIMIT;

  // Identify words served by the block
  logic [15:0] id_mux;
  always_comb begin
    id_mux = 16'h0000;
    if (id_word_sel == lbatf_pkg::ID_WORD_CMDSET) begin
      id_mux[lbatf_pkg::ID_BIT_LBA48] = 1'b1;
    end
    if (id_word_sel >= lbatf_pkg::ID_WORD_MAXLO && id_word_sel <= lbatf_pkg::ID_WORD_MAXHI) begin
      unique case (id_word_sel[1:0])
        2'h0: id_mux = native_max[15:0];
        2'h1: id_mux = native_max[31:16];
        2'h2: id_mux = native_max[47:32];
        2'h3: id_mux = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devctl_r <= lbatf_pkg::DEVCTL_RST;
      devhead_r <= 8'h00;
    end else begin
      devctl_r <= devctl_nxt;
      if (wr_devhead) begin
        devhead_r <= wr_data;
      end
    end
  end

  // Upper-byte select mirrors the control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upper_byte_read_select <= 1'b0;
    end else begin
      upper_byte_read_select <= devctl_nxt[lbatf_pkg::UPPER_SEL_BIT];
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= rd_en ? rd_mux : 8'h00;
      rd_valid <= rd_en;
    end
  end

  // Command issue: 28-bit and 48-bit forms decoded per command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid    <= 1'b0;
      cmd_code     <= 8'h00;
      cmd_is_48    <= 1'b0;
      cmd_lba_mode <= 1'b0;
      cmd_chs_err  <= 1'b0;
      cmd_count    <= 16'h0000;
      cmd_features <= 16'h0000;
      cmd_lba      <= 48'h0;
    end else begin
      cmd_valid <= wr_command;
      if (wr_command) begin
        cmd_code     <= wr_data;
        cmd_is_48    <= cmd_ext_in;
        cmd_lba_mode <= lba_mode;
        cmd_chs_err  <= cmd_ext_in && !lba_mode;
        cmd_count    <= cmd_ext_in ? count_16 : {8'h00, pair_new[1]};
        cmd_features <= cmd_ext_in ? feat_16 : {8'h00, pair_new[0]};
        cmd_lba      <= cmd_ext_in ? lba_48 : lba_28;
      end
    end
  end

  // Native max answers and identify word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      max_answer_48 <= 48'h0;
      max_answer_28 <= 48'h0;
      id_word       <= 16'h0000;
    end else begin
      max_answer_48 <= native_max;
      max_answer_28 <= clamp_28;
      id_word       <= id_mux;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_shift;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && reg_sel == lbatf_pkg::REG_SECCNT) |=> (pair_old[1] == $past(pair_new[1]) && pair_new[1] == $past(wr_data));
  endproperty
  a_shift: assert property (p_shift) else $error("two-deep shift wrong");

  property p_sel_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && reg_sel[3] == 1'b0) |=> !upper_byte_read_select;
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("select not cleared");

  property p_read_prior;
    @(posedge clk) disable iff (!rst_n)
      (rd_en && ub_sel && reg_sel == lbatf_pkg::REG_CYLHI && !wr_en) |=> (rd_data == $past(pair_old[4]));
  endproperty
  a_read_prior: assert property (p_read_prior) else $error("prior not returned");

  property p_read_new;
    @(posedge clk) disable iff (!rst_n)
      (rd_en && !ub_sel && reg_sel == lbatf_pkg::REG_FEATURES) |=> (rd_data == $past(pair_new[0]));
  endproperty
  a_read_new: assert property (p_read_new) else $error("newest not returned");

  property p_clamp;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> (max_answer_28 == (($past(native_max) <= lbatf_pkg::LBA28_LIMIT) ?
                                  $past(native_max) : lbatf_pkg::LBA28_LIMIT));
  endproperty
  a_clamp: assert property (p_clamp) else $error("28-bit max not clamped");

  property p_count16;
    @(posedge clk) disable iff (!rst_n)
      (wr_command && cmd_ext_in) |=> (cmd_count == {$past(pair_old[1]), $past(pair_new[1])});
  endproperty
  a_count16: assert property (p_count16) else $error("16-bit count wrong");

  property p_chs;
    @(posedge clk) disable iff (!rst_n)
      (wr_command && cmd_ext_in && !devhead_r[lbatf_pkg::LBA_MODE_BIT]) |=> (cmd_valid && cmd_chs_err);
  endproperty
  a_chs: assert property (p_chs) else $error("CHS 48-bit not flagged");

  property p_id83;
    @(posedge clk) disable iff (!rst_n)
      (id_word_sel == lbatf_pkg::ID_WORD_CMDSET) |=> id_word[lbatf_pkg::ID_BIT_LBA48];
  endproperty
  a_id83: assert property (p_id83) else $error("48-bit support bit missing");

  c_upper_read: cover property (@(posedge clk) disable iff (!rst_n) rd_en && ub_sel);
  c_cmd48: cover property (@(posedge clk) disable iff (!rst_n) cmd_valid && cmd_is_48);
  c_clamped: cover property (@(posedge clk) disable iff (!rst_n) native_max > lbatf_pkg::LBA28_LIMIT);

endmodule : lbatf_regs

// *** lbatf_host.sv ***
// Host adapter model issuing task-file register accesses
`timescale 1ns/1ps
module lbatf_host (
  // Clock
  input  wire logic       clk,
  // Access strobes and data
  output logic            wr_en,
  output logic            rd_en,
  output logic      [3:0] reg_sel,
  output logic      [7:0] wr_data,
  // Read answer
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // Idle bus from time zero
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    reg_sel = 4'h0;
    wr_data = 8'h00;
  end

  // One write, strobe sampled at a single edge
  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    reg_sel <= r;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~d; // Released data does not keep its last value
  endtask : wr

  // Set upper-byte select before fetching a prior entry
  task automatic sel_upper;
    wr(lbatf_pkg::REG_DEVCTL, 8'h80);
  endtask : sel_upper

  // One read, answer taken within a bounded wait
  task automatic rd(input logic [3:0] r, output logic [7:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    rd_en   <= 1'b1;
    reg_sel <= r;
    @(posedge clk);
    rd_en   <= 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d  = rd_data;
        ok = 1'b1;
      end else begin
        @(posedge clk);
      end
    end
  endtask : rd
endmodule : lbatf_host

// *** lbatf_tb.sv ***
// Self-checking testbench for the 48-bit task-file register block
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, wr_en, rd_en, rd_valid, cmd_valid, cmd_ext_in;
  logic        cmd_is_48, cmd_lba_mode, cmd_chs_err, upper_byte_read_select;
  logic [3:0]  reg_sel;
  logic [7:0]  wr_data, rd_data, cmd_code;
  logic [15:0] cmd_count, cmd_features, id_word;
  logic [47:0] cmd_lba, native_max, max_answer_48, max_answer_28;
  logic [6:0]  id_word_sel;
  int          n_errors, checked;

  // Clock of 10 ns period
  initial clk = 1'b0;
  always #5 clk = ~clk;

  lbatf_regs dut_u (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .reg_sel(reg_sel),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_is_48(cmd_is_48), .cmd_lba_mode(cmd_lba_mode),
    .cmd_chs_err(cmd_chs_err), .cmd_count(cmd_count), .cmd_features(cmd_features),
    .cmd_lba(cmd_lba), .upper_byte_read_select(upper_byte_read_select),
    .native_max(native_max), .cmd_ext_in(cmd_ext_in), .max_answer_48(max_answer_48),
    .max_answer_28(max_answer_28), .id_word_sel(id_word_sel), .id_word(id_word));

  lbatf_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .reg_sel(reg_sel),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [3:0] r, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic       ok;
    host_u.rd(r, d, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected %s expected answer seen none", what);
      final_report();
    end
    chk(what, d, exp);
  endtask : rd_chk

  task automatic sel_chk(input logic exp);
    @(posedge clk);
    #1;
    chk("select", upper_byte_read_select, exp);
  endtask : sel_chk

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_fifo;
    int         i;
    logic [3:0] r;
    logic [7:0] b;
    for (i = 0; i < 5; i++) begin
      r = lbatf_pkg::REG_FEATURES + 4'(i);
      b = 8'(i);
      host_u.wr(r, 8'h10 | b);
      host_u.wr(r, 8'h20 | b);
      rd_chk(r, 8'h20 | b, "newest");
      host_u.sel_upper();
      sel_chk(1'b1);
      rd_chk(r, 8'h10 | b, "prior");
      host_u.wr(r, 8'h30 | b);
      sel_chk(1'b0);
      rd_chk(r, 8'h30 | b, "newest under select");
      host_u.sel_upper();
      rd_chk(r, 8'h20 | b, "shifted prior");
    end
    host_u.wr(lbatf_pkg::REG_DEVHEAD, 8'h00);
    sel_chk(1'b0);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_cmd(input logic ext, input logic [7:0] head, input logic [7:0] code);
    int   i;
    logic seen;
    seen = 1'b0;
    host_u.wr(lbatf_pkg::REG_DEVHEAD, head);
    for (i = 0; i < 10; i++) begin
      host_u.wr(lbatf_pkg::REG_FEATURES + 4'(i % 5), (i < 5) ? 8'hf0 | 8'(i) : 8'h60 | 8'(i - 5));
    end
    @(posedge clk);
    cmd_ext_in <= ext;
    host_u.wr(lbatf_pkg::REG_COMMAND, code);
    for (i = 0; i < 4 && !seen; i++) begin
      #1;
      if (cmd_valid === 1'b1) seen = 1'b1;
      else @(posedge clk);
    end
    if (!seen) begin
      n_errors++;
      $display("unexpected command pulse expected 1 seen 0");
      final_report();
    end
    chk("code", cmd_code, code);
    chk("is 48", cmd_is_48, ext);
    chk("lba mode", cmd_lba_mode, head[6]);
    if (ext) begin
      chk("count", cmd_count, 16'hf161);
      chk("features", cmd_features, 16'hf060);
      chk("lba48", cmd_lba, 48'hf4f3f2_646362);
      chk("chs error", cmd_chs_err, !head[6]);
    end else begin
      chk("lba28", cmd_lba, {20'h00000, head[3:0], 24'h646362});
      chk("count 28", cmd_count, 16'h0061);
      chk("features 28", cmd_features, 16'h0060);
      chk("chs error 28", cmd_chs_err, 1'b0);
    end
    $display("test command done");
  endtask : t_cmd

  task automatic t_max;
    int          i, w;
    logic [47:0] v;
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 48'h0000_0fff_ffff : (i == 1) ? 48'h0000_1000_0000 : 48'h8a9b_7c6d_5e4f;
      @(posedge clk);
      native_max <= v;
      repeat (2) @(posedge clk);
      #1;
      chk("max 48", max_answer_48, v);
      chk("max 28", max_answer_28, (v > lbatf_pkg::LBA28_LIMIT) ? lbatf_pkg::LBA28_LIMIT : v);
    end
    for (w = 83; w < 104; w++) begin
      if (w == 83 || w > 99) begin
        @(posedge clk);
        id_word_sel <= 7'(w);
        repeat (2) @(posedge clk);
        #1;
        if (w == 83) chk("word 83", id_word[10], 1'b1);
        else chk("max word", id_word, (w == 103) ? 16'h0000 : v[16 * (w - 100) +: 16]);
      end
    end
    $display("test native max done");
  endtask : t_max

  // Main sequence
  initial begin
    n_errors    = 0;
    checked     = 0;
    rst_n       = 1'b0;
    native_max  = 48'h0000_0000_0000;
    cmd_ext_in  = 1'b0;
    id_word_sel = 7'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sel_chk(1'b0);
    t_fifo();
    t_cmd(1'b1, 8'h40, 8'h25);
    t_cmd(1'b0, 8'h4a, 8'hc8);
    t_cmd(1'b1, 8'h00, 8'h35);
    t_max();
    final_report();
  end
endmodule : testbench
